/* core/mts_pkg.sv */
/*
 * Constants shared by the transmit control/status and receive status logic:
 * register offsets, field positions, reset value and timing counts.
 * Assumes a single 100 MHz system clock.
 */
package mts_pkg;
    localparam int unsigned CLK_PERIOD_PS = 10000;
    // Late collision window, in nanoseconds (51.2 us)
    localparam int unsigned LATE_WINDOW_NS = 51200;
    // Excessive deferral limit, in nanoseconds (3.2 ms)
    localparam int unsigned DEFER_LIMIT_NS = 3200000;
    // Least times, rounded up to whole cycles
    localparam int unsigned LATE_WINDOW_CYCLES = (LATE_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DEFER_LIMIT_CYCLES = (DEFER_LIMIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned MAX_COLLISIONS = 16;

    localparam logic [5:0] OFS_TX_CTRL = 6'h03;
    localparam logic [5:0] OFS_RX_STATUS = 6'h05;

    localparam logic [15:0] TCR_RESET = 16'h0101;
    localparam logic [15:0] TCR_WRITABLE = 16'hF000;

    localparam int unsigned B_PROGRAMMABLE_IRQ = 15;
    localparam int unsigned B_LATE_COLL_TIMER_START = 14;
    localparam int unsigned B_FCS_OMIT = 13;
    localparam int unsigned B_DEFER_OFF = 12;
    localparam int unsigned B_EXD = 10;
    localparam int unsigned B_DEF = 9;
    localparam int unsigned B_NO_CARRIER = 8;
    localparam int unsigned B_CARRIER_LOST = 7;
    localparam int unsigned B_EXC = 6;
    localparam int unsigned B_OWC = 5;
    localparam int unsigned B_PMB = 3;
    localparam int unsigned B_FU = 2;
    localparam int unsigned B_BCM = 1;
    localparam int unsigned B_PTX = 0;

    localparam int unsigned RB_COL = 4;
    localparam int unsigned RB_CRC = 3;
    localparam int unsigned RB_FAE = 2;
    localparam int unsigned RB_LBK = 1;
    localparam int unsigned RB_PRX = 0;
endpackage

/* core/mts_rx_if.sv */
/*
 * Receive completion events and the resulting status bits, between the
 * top block and its receive status module. Events are one-cycle pulses.
 */
`timescale 1ns/1ps
interface mts_rx_if;
    logic done;
    logic collision;
    logic crc_bad;
    logic misaligned;
    logic runt;
    logic loopback;
    logic [4:0] status;
    modport src (output done, output collision, output crc_bad, output misaligned, output runt,
        output loopback, input status);
    modport sink (input done, input collision, input crc_bad, input misaligned, input runt,
        input loopback, output status);
endinterface

/* core/mts_interval_timer.sv */
/*
 * Saturating interval timer: counts while run is high, restarts on clear.
 * Assumes the caller holds clear whenever the measured interval ends.
 */
`timescale 1ns/1ps
module mts_interval_timer #(
    parameter int unsigned CYCLES = 16
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run,
    input wire logic clear,
    output logic expired
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] count_r;

    if (CYCLES < 1) begin : g_check
        $error("mts_interval_timer: CYCLES must be at least 1");
    end

    always_ff @(posedge clk_sys) begin
        if (reset || clear) begin
            count_r <= '0;
        end else if (run && count_r != LIMIT) begin
            count_r <= count_r + W'(1);
        end
    end

    assign expired = (count_r == LIMIT);
endmodule

/* core/mts_rx_status.sv */
/*
 * Receive status bits 4..0, captured at the end of each received packet.
 * Assumes event inputs are valid in the cycle where done is high.
 */
`timescale 1ns/1ps
module mts_rx_status (
    input wire logic clk_sys,
    input wire logic reset,
    mts_rx_if.sink rx
);
    logic [4:0] status_r;
    logic good;

    // Misalignment alone is no error; only with a bad check does it count
    assign good = !rx.crc_bad && !rx.runt && !rx.collision;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_r <= 5'h00;
        end else if (rx.done) begin
            status_r[mts_pkg::RB_COL] <= rx.collision;
            status_r[mts_pkg::RB_CRC] <= rx.crc_bad && !rx.misaligned;
            status_r[mts_pkg::RB_FAE] <= rx.crc_bad && rx.misaligned;
            status_r[mts_pkg::RB_LBK] <= rx.loopback && good;
            status_r[mts_pkg::RB_PRX] <= good;
        end
    end

    assign rx.status = status_r;
endmodule

/* core/mts_txrx_status_ctrl.sv */
/*
 * Transmit control/status register with per-frame mode loading, status
 * capture and write-back, plus the receive status bits.
 * Assumes the transmit engine, descriptor fetcher and receiver supply the
 * event pulses below, all synchronous to clk_sys.
 */
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module mts_txrx_status_ctrl #(
    parameter int unsigned LATE_WINDOW_CYCLES = mts_pkg::LATE_WINDOW_CYCLES,
    parameter int unsigned DEFER_LIMIT_CYCLES = mts_pkg::DEFER_LIMIT_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic tx_desc_fetch,
    input wire logic [15:0] tx_descriptor_config_word,
    input wire logic tx_start,
    input wire logic tx_preamble_start,
    input wire logic tx_sfd_done,
    input wire logic tx_frame_active,
    input wire logic tx_deferring,
    input wire logic tx_collision,
    input wire logic carrier_sense,
    input wire logic tx_underrun_event,
    input wire logic tx_length_event,
    input wire logic tx_monitor_event,
    input wire logic tx_end,
    input wire logic tx_status_written,
    input wire logic rx_done,
    input wire logic rx_collision,
    input wire logic rx_crc_bad,
    input wire logic rx_misaligned,
    input wire logic rx_runt,
    input wire logic rx_loopback,
    output logic tx_fcs_append,
    output logic tx_abort,
    output logic tx_status_valid,
    output logic [15:0] tx_descriptor_status_word,
    output logic programmable_irq,
    output logic [4:0] rx_status
);
    if (LATE_WINDOW_CYCLES < 1 || DEFER_LIMIT_CYCLES < 1) begin : g_check
        $error("mts_txrx_status_ctrl: timer counts must be at least 1");
    end

    typedef enum logic [2:0] {
        MTS_IDLE = 3'b001,
        MTS_SEND = 3'b010,
        MTS_WRITEBACK = 3'b100
    } mts_state_t;

    mts_state_t state_r;
    mts_state_t state_nxt;

    logic [15:0] tcr_r;
    logic [4:0] coll_count_r;
    logic window_started_r;
    logic late_expired;
    logic defer_expired;
    logic defer_run;
    logic late_run;
    logic coll_limit_hit;
    logic defer_fire;
    logic in_frame;
    logic [15:0] rdata_nxt;

    mts_rx_if rx_bus ();

    assign rx_bus.done = rx_done;
    assign rx_bus.collision = rx_collision;
    assign rx_bus.crc_bad = rx_crc_bad;
    assign rx_bus.misaligned = rx_misaligned;
    assign rx_bus.runt = rx_runt;
    assign rx_bus.loopback = rx_loopback;

    mts_rx_status u_rx_status (
        .clk_sys(clk_sys),
        .reset(reset),
        .rx(rx_bus.sink)
    );

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_status <= 5'h00;
        end else begin
            rx_status <= rx_bus.status;
        end
    end

    // Frame sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            MTS_IDLE: begin
                if (tx_start) begin
                    state_nxt = MTS_SEND;
                end
            end
            MTS_SEND: begin
                if (tx_end) begin
                    state_nxt = MTS_WRITEBACK;
                end
            end
            MTS_WRITEBACK: begin
                if (tx_status_written) begin
                    state_nxt = MTS_IDLE;
                end
            end
            default: begin
                state_nxt = MTS_IDLE;
            end
        endcase
    end

    // Soft reset drops the frame sequence but leaves the register alone
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            state_r <= MTS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign in_frame = (state_r == MTS_SEND);

    // Late collision window start point
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset || tx_start || tx_end) begin
            window_started_r <= 1'b0;
        end else if (in_frame && tcr_r[mts_pkg::B_LATE_COLL_TIMER_START] && tx_preamble_start) begin
            window_started_r <= 1'b1;
        end else if (in_frame && !tcr_r[mts_pkg::B_LATE_COLL_TIMER_START] && tx_sfd_done) begin
            window_started_r <= 1'b1;
        end
    end

    assign late_run = in_frame && window_started_r;

    mts_interval_timer #(
        .CYCLES(LATE_WINDOW_CYCLES)
    ) u_late_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(late_run),
        .clear(!window_started_r),
        .expired(late_expired)
    );

    // Disabled timer never runs, so bit 10 cannot rise
    assign defer_run = in_frame && tx_deferring && !tcr_r[mts_pkg::B_DEFER_OFF];

    mts_interval_timer #(
        .CYCLES(DEFER_LIMIT_CYCLES)
    ) u_defer_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(defer_run),
        .clear(!defer_run),
        .expired(defer_expired)
    );

    assign defer_fire = defer_run && defer_expired && !tcr_r[mts_pkg::B_EXD];
    assign coll_limit_hit = in_frame && tx_collision &&
        (coll_count_r == 5'(mts_pkg::MAX_COLLISIONS - 1));

    // Collisions on the current frame
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset || tx_start) begin
            coll_count_r <= 5'h00;
        end else if (in_frame && tx_collision && coll_count_r != 5'(mts_pkg::MAX_COLLISIONS)) begin
            coll_count_r <= coll_count_r + 5'h01;
        end
    end

    // Transmit control/status register; clears come first so sets win
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tcr_r <= mts_pkg::TCR_RESET;
        end else begin
            if (reg_wr && reg_addr == mts_pkg::OFS_TX_CTRL) begin
                tcr_r[15:12] <= reg_wdata[15:12];
            end
            if (tx_status_written && state_r == MTS_WRITEBACK) begin
                tcr_r[mts_pkg::B_DEF] <= 1'b0;
                tcr_r[mts_pkg::B_OWC] <= 1'b0;
            end
            if (tx_start && state_r == MTS_IDLE) begin
                tcr_r[15:12] <= tx_descriptor_config_word[15:12];
                tcr_r[mts_pkg::B_EXD] <= 1'b0;
                tcr_r[mts_pkg::B_CARRIER_LOST] <= 1'b0;
                tcr_r[mts_pkg::B_EXC] <= 1'b0;
                tcr_r[mts_pkg::B_BCM] <= 1'b0;
                tcr_r[mts_pkg::B_NO_CARRIER] <= 1'b1;
                tcr_r[mts_pkg::B_PMB] <= 1'b0;
                tcr_r[mts_pkg::B_FU] <= 1'b0;
                tcr_r[mts_pkg::B_PTX] <= 1'b0;
            end
            if (in_frame) begin
                if (defer_fire) begin
                    tcr_r[mts_pkg::B_EXD] <= 1'b1;
                end
                if (tx_deferring && coll_count_r == 5'h00) begin
                    tcr_r[mts_pkg::B_DEF] <= 1'b1;
                end else if (tx_collision) begin
                    tcr_r[mts_pkg::B_DEF] <= 1'b0;
                end
                if (tx_frame_active && carrier_sense) begin
                    tcr_r[mts_pkg::B_NO_CARRIER] <= 1'b0;
                end
                if (tx_frame_active && !carrier_sense) begin
                    tcr_r[mts_pkg::B_CARRIER_LOST] <= 1'b1;
                end
                if (coll_limit_hit) begin
                    tcr_r[mts_pkg::B_EXC] <= 1'b1;
                end
                if (tx_collision && late_expired) begin
                    tcr_r[mts_pkg::B_OWC] <= 1'b1;
                end
                if (tx_monitor_event) begin
                    tcr_r[mts_pkg::B_PMB] <= 1'b1;
                end
                if (tx_underrun_event) begin
                    tcr_r[mts_pkg::B_FU] <= 1'b1;
                end
                if (tx_length_event) begin
                    tcr_r[mts_pkg::B_BCM] <= 1'b1;
                end
                if (tx_end && !tcr_r[mts_pkg::B_EXD] && !tcr_r[mts_pkg::B_EXC] &&
                    !tcr_r[mts_pkg::B_FU] && !tcr_r[mts_pkg::B_BCM] && !coll_limit_hit && !defer_fire) begin
                    tcr_r[mts_pkg::B_PTX] <= 1'b1;
                end
            end
        end
    end

    // Status word goes out two cycles after tx_end, once TX_PACKET_OK has settled
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_status_valid <= 1'b0;
            tx_descriptor_status_word <= 16'h0000;
        end else begin
            tx_status_valid <= 1'b0;
            if (state_r == MTS_WRITEBACK && !tx_status_valid && !tx_status_written &&
                $past(in_frame)) begin
                tx_status_valid <= 1'b1;
                tx_descriptor_status_word <= {coll_count_r, tcr_r[10:0]};
            end
        end
    end

    // Abort requests to the transmit engine
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_abort <= 1'b0;
        end else begin
            tx_abort <= defer_fire || coll_limit_hit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_fcs_append <= 1'b1;
        end else begin
            tx_fcs_append <= !tcr_r[mts_pkg::B_FCS_OMIT];
        end
    end

    // Interrupt only on a new 0-to-1 of the register copy; back-to-back sets are lost
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            programmable_irq <= 1'b0;
        end else begin
            programmable_irq <= tx_desc_fetch && tx_descriptor_config_word[mts_pkg::B_PROGRAMMABLE_IRQ] &&
                !tcr_r[mts_pkg::B_PROGRAMMABLE_IRQ];
        end
    end

    // Register read port; bits 11 and 4 are never stored as ones
    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_addr == mts_pkg::OFS_TX_CTRL) begin
            rdata_nxt = tcr_r & 16'hF7EF;
        end else if (reg_addr == mts_pkg::OFS_RX_STATUS) begin
            rdata_nxt = {11'h000, rx_bus.status};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

/* verif/mts_chk.sv */
/* Concurrent checks on the ports of mts_txrx_status_ctrl.
   Assumes one clock and that frames arrive start, events, end, write-back. */
`timescale 1ns/1ps
module mts_chk (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic tx_desc_fetch,
    input wire logic [15:0] tx_descriptor_config_word,
    input wire logic tx_start,
    input wire logic tx_deferring,
    input wire logic tx_collision,
    input wire logic tx_end,
    input wire logic tx_status_written,
    input wire logic rx_done,
    input wire logic rx_collision,
    input wire logic rx_crc_bad,
    input wire logic rx_misaligned,
    input wire logic rx_runt,
    input wire logic tx_fcs_append,
    input wire logic tx_abort,
    input wire logic tx_status_valid,
    input wire logic [15:0] tx_descriptor_status_word,
    input wire logic programmable_irq,
    input wire logic [4:0] rx_status
);
    logic busy_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Tracks a taken frame, since a start while busy is ignored
    always_ff @(posedge clk_sys) begin
        if (reset || soft_reset) begin
            busy_r <= 1'b0;
        end else if (tx_start) begin
            busy_r <= 1'b1;
        end else if (tx_status_written) begin
            busy_r <= 1'b0;
        end
    end
    rd_reserved_a: assert property (reg_rd && reg_addr == mts_pkg::OFS_TX_CTRL
        |=> reg_rdata[11] == 1'b0 && reg_rdata[4] == 1'b0) else $error("reserved bit reads one");
    wr_fcs_a: assert property (reg_wr && reg_addr == mts_pkg::OFS_TX_CTRL && !tx_start
        |-> ##2 tx_fcs_append == !$past(reg_wdata[13], 2)) else $error("written mode not applied");
    start_fcs_a: assert property (tx_start && !busy_r && !reg_wr
        |-> ##2 tx_fcs_append == !$past(tx_descriptor_config_word[13], 2)) else $error("frame mode not loaded");
    irq_cause_a: assert property (programmable_irq
        |-> $past(tx_desc_fetch) && $past(tx_descriptor_config_word[15])) else $error("stray interrupt");
    abort_cause_a: assert property (tx_abort
        |-> $past(tx_collision) || $past(tx_deferring)) else $error("abort without cause");
    status_lat_a: assert property (tx_end && busy_r |-> ##2 tx_status_valid)
        else $error("status word late");
    status_word_a: assert property (tx_status_valid
        |-> tx_descriptor_status_word[4] == 1'b0 ##1 !tx_status_valid) else $error("bad status strobe");
    rx_flags_a: assert property (rx_done |-> ##2 rx_status[4:2] == $past({rx_collision,
        rx_crc_bad && !rx_misaligned, rx_crc_bad && rx_misaligned}, 2)) else $error("receive error flags wrong");
    rx_ok_a: assert property (rx_done
        |-> ##2 rx_status[0] == $past(!rx_crc_bad && !rx_runt && !rx_collision, 2)) else $error("receive ok wrong");
endmodule

bind mts_txrx_status_ctrl mts_chk mts_chk_inst (
    .clk_sys, .reset, .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_desc_fetch,
    .tx_descriptor_config_word, .tx_start, .tx_deferring, .tx_collision, .tx_end, .tx_status_written,
    .rx_done, .rx_collision, .rx_crc_bad, .rx_misaligned, .rx_runt, .tx_fcs_append, .tx_abort,
    .tx_status_valid, .tx_descriptor_status_word, .programmable_irq, .rx_status
);

/* verif/mts_medium_model.sv */
/* Transmit engine and medium stand-in: fetch, deferral, preamble, frame, end.
   Assumes the bench calls send_frame and waits for it to return. */
`timescale 1ns/1ps
module mts_medium_model (
    input wire logic clk_sys,
    input wire logic tx_abort,
    input wire logic tx_status_valid,
    input wire logic [15:0] tx_descriptor_status_word,
    output logic tx_desc_fetch,
    output logic [15:0] tx_descriptor_config_word,
    output logic tx_start,
    output logic tx_preamble_start,
    output logic tx_sfd_done,
    output logic tx_frame_active,
    output logic tx_deferring,
    output logic tx_collision,
    output logic carrier_sense,
    output logic tx_underrun_event,
    output logic tx_length_event,
    output logic tx_monitor_event,
    output logic tx_end,
    output logic tx_status_written
);
    logic [15:0] last_word;
    initial begin
        tx_descriptor_config_word = 16'h0000;
        {tx_desc_fetch, tx_start, tx_preamble_start, tx_sfd_done, tx_frame_active, tx_deferring,
            tx_collision, carrier_sense, tx_underrun_event, tx_length_event, tx_monitor_event,
            tx_end, tx_status_written} = 13'h0000;
    end
    task automatic send_frame(input logic [15:0] cfg, input int nc, input int gap, input int dfr,
        input logic crs, input logic [2:0] ev);
        int i;
        logic stop;
        stop = 1'b0;
        last_word = 16'hXXXX;
        @(posedge clk_sys);
        tx_descriptor_config_word <= cfg;
        tx_desc_fetch <= 1'b1;
        @(posedge clk_sys);
        tx_desc_fetch <= 1'b0;
        tx_start <= 1'b1;
        @(posedge clk_sys);
        tx_start <= 1'b0;
        tx_deferring <= (dfr > 0);
        // Deferral gives up as soon as the block aborts
        for (i = 0; i < dfr && !stop; i++) begin
            @(posedge clk_sys);
            stop = tx_abort;
        end
        tx_deferring <= 1'b0;
        if (!stop) begin
            tx_preamble_start <= 1'b1;
            @(posedge clk_sys);
            tx_preamble_start <= 1'b0;
            repeat (11) @(posedge clk_sys);
            tx_sfd_done <= 1'b1;
            tx_frame_active <= 1'b1;
            carrier_sense <= crs;
            @(posedge clk_sys);
            tx_sfd_done <= 1'b0;
            repeat (gap) @(posedge clk_sys);
            {tx_monitor_event, tx_length_event, tx_underrun_event} <= ev;
            @(posedge clk_sys);
            {tx_monitor_event, tx_length_event, tx_underrun_event} <= 3'h0;
            for (i = 0; i < nc; i++) begin
                tx_collision <= 1'b1;
                @(posedge clk_sys);
                tx_collision <= 1'b0;
                @(posedge clk_sys);
            end
            repeat (4) @(posedge clk_sys);
            tx_frame_active <= 1'b0;
            carrier_sense <= 1'b0;
        end
        tx_end <= 1'b1;
        @(posedge clk_sys);
        tx_end <= 1'b0;
        // Bounded wait, so a missing strobe leaves an unknown word behind
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            if (tx_status_valid === 1'b1) begin
                last_word = tx_descriptor_status_word;
                break;
            end
        end
        tx_status_written <= 1'b1;
        @(posedge clk_sys);
        tx_status_written <= 1'b0;
    endtask
endmodule

/* verif/mts_txrx_status_ctrl_tb.sv */
/* Self-checking bench for mts_txrx_status_ctrl with short timer counts.
   Assumes the medium model and checker are compiled alongside. */
`timescale 1ns/1ps
module mts_txrx_status_ctrl_tb;
    logic clk_sys, reset, soft_reset, reg_wr, reg_rd, tx_desc_fetch, tx_start, tx_preamble_start;
    logic tx_sfd_done, tx_frame_active, tx_deferring, tx_collision, carrier_sense, tx_underrun_event;
    logic tx_length_event, tx_monitor_event, tx_end, tx_status_written, rx_done, rx_collision;
    logic rx_crc_bad, rx_misaligned, rx_runt, rx_loopback, tx_fcs_append, tx_abort, tx_status_valid;
    logic programmable_irq;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, cfg_word, status_word;
    logic [4:0] rx_status;
    int fail_count, n_checks, irq_hits, abort_hits;
    mts_txrx_status_ctrl #(.LATE_WINDOW_CYCLES(40), .DEFER_LIMIT_CYCLES(40)) mts_txrx_status_ctrl_inst (
        .clk_sys, .reset, .soft_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_desc_fetch,
        .tx_descriptor_config_word(cfg_word), .tx_start, .tx_preamble_start, .tx_sfd_done, .tx_frame_active,
        .tx_deferring, .tx_collision, .carrier_sense, .tx_underrun_event, .tx_length_event, .tx_monitor_event,
        .tx_end, .tx_status_written, .rx_done, .rx_collision, .rx_crc_bad, .rx_misaligned, .rx_runt,
        .rx_loopback, .tx_fcs_append, .tx_abort, .tx_status_valid, .tx_descriptor_status_word(status_word),
        .programmable_irq, .rx_status
    );
    mts_medium_model mts_medium_model_inst (
        .clk_sys, .tx_abort, .tx_status_valid, .tx_descriptor_status_word(status_word), .tx_desc_fetch,
        .tx_descriptor_config_word(cfg_word), .tx_start, .tx_preamble_start, .tx_sfd_done, .tx_frame_active,
        .tx_deferring, .tx_collision, .carrier_sense, .tx_underrun_event, .tx_length_event,
        .tx_monitor_event, .tx_end, .tx_status_written
    );
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (programmable_irq === 1'b1) begin
            irq_hits++;
        end
        if (tx_abort === 1'b1) begin
            abort_hits++;
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & mask, exp);
    endtask
    task automatic frame(input logic [15:0] cfg, input int nc, input int gap, input int dfr,
        input logic crs, input logic [2:0] ev, input logic [15:0] exp);
        mts_medium_model_inst.send_frame(cfg, nc, gap, dfr, crs, ev);
        check(mts_medium_model_inst.last_word, exp);
    endtask
    task automatic t_regs;
        rd_chk(6'h03, 16'hFFFF, 16'h0101);
        rd_chk(6'h3F, 16'hFFFF, 16'h0000);
        reg_write(6'h03, 16'hF7FF);
        rd_chk(6'h03, 16'hFFFF, 16'hF101);
        check({15'h0000, tx_fcs_append}, 16'h0000);
        reg_write(6'h05, 16'hFFFF);
        rd_chk(6'h05, 16'hFFFF, 16'h0000);
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        rd_chk(6'h03, 16'hFFFF, 16'hF101);
        reg_write(6'h03, 16'h0000);
        rd_chk(6'h03, 16'hFFFF, 16'h0101);
        $display("t_regs done");
    endtask
    task automatic t_frames;
        frame(16'h2000, 0, 4, 0, 1'b1, 3'h0, 16'h0001);
        check({15'h0000, tx_fcs_append}, 16'h0000);
        rd_chk(6'h03, 16'hF000, 16'h2000);
        frame(16'h0000, 16, 0, 0, 1'b1, 3'h0, 16'h8040);
        rd_chk(6'h03, 16'h0260, 16'h0040);
        frame(16'h4000, 1, 35, 0, 1'b1, 3'h0, 16'h0821);
        rd_chk(6'h03, 16'h0260, 16'h0000);
        frame(16'h0000, 1, 35, 0, 1'b1, 3'h0, 16'h0801);
        $display("t_frames done");
    endtask
    task automatic t_defer;
        frame(16'h0000, 0, 4, 50, 1'b1, 3'h0, 16'h0700);
        frame(16'h1000, 0, 4, 50, 1'b1, 3'h0, 16'h0201);
        rd_chk(6'h03, 16'h0600, 16'h0000);
        frame(16'h0000, 0, 4, 0, 1'b0, 3'h0, 16'h0181);
        frame(16'h0000, 0, 4, 0, 1'b1, 3'h1, 16'h0004);
        frame(16'h0000, 0, 4, 0, 1'b1, 3'h6, 16'h000A);
        check(16'(abort_hits), 16'h0002);
        $display("t_defer done");
    endtask
    // Software sets the interrupt bit twice running, to show a repeat does not fire, then clears and sets it
    task automatic t_irq;
        logic [15:0] cfgs [4] = '{16'h8000, 16'h8000, 16'h0000, 16'h8000};
        logic [15:0] hits [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0001};
        int base;
        for (int i = 0; i < 4; i++) begin
            base = irq_hits;
            frame(cfgs[i], 0, 4, 0, 1'b1, 3'h0, 16'h0001);
            check(16'(irq_hits - base), hits[i]);
        end
        $display("t_irq done");
    endtask
    task automatic t_rx;
        logic ok;
        logic [15:0] exp;
        for (int i = 0; i < 32; i++) begin
            @(posedge clk_sys);
            {rx_loopback, rx_runt, rx_misaligned, rx_crc_bad, rx_collision} <= 5'(i);
            rx_done <= 1'b1;
            ok = !i[1] && !i[3] && !i[0];
            exp = {11'h000, i[0], i[1] && !i[2], i[1] && i[2], i[4] && ok, ok};
            @(posedge clk_sys);
            rx_done <= 1'b0;
            reg_addr <= 6'h05;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 check(reg_rdata, exp);
            check({11'h000, rx_status}, exp);
        end
        $display("t_rx done");
    endtask
    initial begin
        {reset, soft_reset, reg_wr, reg_rd, rx_done, rx_collision} = 6'h21;
        {rx_crc_bad, rx_misaligned, rx_runt, rx_loopback} = 4'h0;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        fail_count = 0;
        n_checks = 0;
        irq_hits = 0;
        abort_hits = 0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs;
        t_frames;
        t_defer;
        t_irq;
        t_rx;
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        close_out;
    end
endmodule
